//--- hw/dec_diag_checks.sv
/*
 * Diagnostic check enables and error flags of the converter, with the serial
 * register port, the input monitors, the regulator trip tests and the interface, map and ROM CRC checks.
 * Assumes a 10 MHz clock, a registered ROM answering one cycle after its address,
 * conversion and saturation events on this clock, and asynchronous analog levels.
 */
`timescale 1ns/1ps
module dec_diag_checks
	import dec_pkg::*;
#(
	parameter int         MAP_CYCLES       = MAP_CHECK_CYCLES,
	parameter logic [7:0] ROM_CRC_EXPECTED = 8'h00
)(
	input  wire logic              i_mclk,
	input  wire logic              i_rstn,
	input  wire logic              i_cs_n,
	input  wire logic              i_sclk,
	input  wire logic              i_din,
	output logic                   o_dout,
	output logic                   o_dout_oe,
	input  wire logic              i_calibrating,
	input  wire logic              i_conv_fail,
	input  wire logic              i_mod_sat,
	input  wire logic              i_pos_over,
	input  wire logic              i_pos_under,
	input  wire logic              i_neg_over,
	input  wire logic              i_neg_under,
	input  wire logic              i_ext_ref_used,
	input  wire logic              i_ref_low,
	input  wire logic              i_dldo_bad,
	input  wire logic              i_aldo_bad,
	output logic                   o_digital_regulator_trip_test,
	output logic                   o_analog_regulator_trip_test,
	output logic [ROM_AW-1:0]      o_rom_addr,
	input  wire logic [7:0]        i_rom_data,
	output logic [23:0]            o_check_enables,
	output logic [23:0]            o_error_flags
);
	localparam int PW = $clog2(POR_CYCLES + 1);

	dec_link_if link ();

	logic [23:0]      enables_reg, errors_reg, errors_next, err_set, snap_reg, clr_mask;
	logic [PW-1:0]    por_reg;
	logic [MON_W-1:0] m1_reg, m2_reg, m3_reg, mon_reg, mon_next;
	logic             busy, readable, wr_enables, wr_commit_reg, err_clear, map_bad;
	logic             rom_valid_reg, rom_bad_reg;
	logic [7:0]       rom_crc_reg;
	logic [ROM_AW-1:0] rom_addr_reg;
	dec_rom_state_t   rom_state_reg, rom_state_next;

	dec_serial u_serial (
		.i_mclk    (i_mclk),
		.i_rstn    (i_rstn),
		.i_cs_n    (i_cs_n),
		.i_sclk    (i_sclk),
		.i_din     (i_din),
		.o_dout    (o_dout),
		.o_dout_oe (o_dout_oe),
		.link      (link.port)
	);

	dec_map_crc #(
		.CHECK_CYCLES (MAP_CYCLES)
	) u_map_crc (
		.i_mclk     (i_mclk),
		.i_rstn     (i_rstn),
		.i_enable   (enables_reg[B_MAP]),
		.i_capture  (wr_commit_reg),
		.i_map      (enables_reg),
		.o_mismatch (map_bad)
	);

	// Writes are locked out while power-on settles or a calibration runs.
	assign busy       = (por_reg != '0) | i_calibrating;
	assign wr_enables = link.wr_stb & ~busy & (link.addr == ADDR_ENABLES);
	assign readable   = (link.addr == ADDR_ENABLES) | (link.addr == ADDR_ERRORS);

	// Read data and the CRC mode go back to the serial front end.
	assign link.rdata  = (link.addr == ADDR_ENABLES) ? enables_reg :
		(link.addr == ADDR_ERRORS) ? errors_reg : 24'h000000;
	assign link.crc_en = enables_reg[B_IF_CRC];

	// Analog levels take three stages; a change counts once stages two and three agree.
	assign mon_next = (m2_reg & ~(m2_reg ^ m3_reg)) | (mon_reg & (m2_reg ^ m3_reg));

	// Each flag is set only through its own enable, the regulator checks also through their trip test enable; trip flags never set.
	assign err_set[23:18]       = 6'h00;
	assign err_set[B_CONV]      = enables_reg[B_CONV] & i_conv_fail;
	assign err_set[B_SAT]       = enables_reg[B_SAT] & i_mod_sat;
	assign err_set[B_POS_OVER]  = enables_reg[B_POS_OVER] & mon_reg[MON_POS_OVER];
	assign err_set[B_POS_UNDER] = enables_reg[B_POS_UNDER] & mon_reg[MON_POS_UNDER];
	assign err_set[B_NEG_OVER]  = enables_reg[B_NEG_OVER] & mon_reg[MON_NEG_OVER];
	assign err_set[B_NEG_UNDER] = enables_reg[B_NEG_UNDER] & mon_reg[MON_NEG_UNDER];
	assign err_set[B_REF]       = enables_reg[B_REF] & i_ext_ref_used & mon_reg[MON_REF];
	assign err_set[B_DLDO_TRIP] = 1'b0;
	assign err_set[B_DLDO_CHK]  = (enables_reg[B_DLDO_CHK] | enables_reg[B_DLDO_TRIP])
		& mon_reg[MON_DLDO];
	assign err_set[B_ALDO_TRIP] = 1'b0;
	assign err_set[B_ALDO_CHK]  = (enables_reg[B_ALDO_CHK] | enables_reg[B_ALDO_TRIP])
		& mon_reg[MON_ALDO];
	assign err_set[B_IGNORE]    = enables_reg[B_IGNORE] & link.wr_stb & busy;
	assign err_set[B_SCLK]      = enables_reg[B_SCLK] & link.cnt_bad;
	assign err_set[B_READ]      = enables_reg[B_READ] & link.rd_stb & ~readable;
	assign err_set[B_WRITE]     = enables_reg[B_WRITE] & link.wr_stb & ~busy
		& (link.addr != ADDR_ENABLES);
	assign err_set[B_IF_CRC]    = enables_reg[B_IF_CRC] & link.crc_bad;
	assign err_set[B_MAP]       = enables_reg[B_MAP] & map_bad;
	assign err_set[B_ROM]       = enables_reg[B_ROM] & rom_bad_reg;

	// Reading the error register clears only the bits that were shifted out,
	// so an event landing during the read survives, and a new set beats the clear.
	assign err_clear   = link.rd_done & (link.addr == ADDR_ERRORS);
	assign clr_mask    = err_clear ? snap_reg : 24'h000000;
	assign errors_next = (errors_reg & ~clr_mask) | err_set;

	// Trip tests are plain levels to the analog supervisors.
	assign o_digital_regulator_trip_test = enables_reg[B_DLDO_TRIP];
	assign o_analog_regulator_trip_test  = enables_reg[B_ALDO_TRIP];
	assign o_rom_addr      = rom_addr_reg;
	assign o_check_enables = enables_reg;
	assign o_error_flags   = errors_reg;

	// Monitor synchroniser.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			m1_reg  <= '0;
			m2_reg  <= '0;
			m3_reg  <= '0;
			mon_reg <= '0;
		end else begin
			m1_reg  <= {i_aldo_bad, i_dldo_bad, i_ref_low, i_neg_under, i_neg_over,
				i_pos_under, i_pos_over};
			m2_reg  <= m1_reg;
			m3_reg  <= m2_reg;
			mon_reg <= mon_next;
		end
	end

	// Power-on window counts down once after reset release.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			por_reg <= PW'(POR_CYCLES);
		end else if (por_reg != '0) begin
			por_reg <= por_reg - PW'(1);
		end
	end

	// Configuration register and the map snapshot strobe one cycle later.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			enables_reg   <= ENABLES_RESET;
			wr_commit_reg <= 1'b0;
		end else begin
			wr_commit_reg <= wr_enables;
			if (wr_enables) begin
				enables_reg <= link.wdata;
			end
		end
	end

	// Error flags and the copy of what a read of them carried.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			errors_reg <= ERRORS_RESET;
			snap_reg   <= 24'h000000;
		end else begin
			errors_reg <= errors_next;
			if (link.rd_stb && link.addr == ADDR_ERRORS) begin
				snap_reg <= errors_reg;
			end
		end
	end

	// ROM walk sequencing: fetch every word once, then hold the verdict.
	always_comb begin
		case (rom_state_reg)
			ROM_FETCH: rom_state_next = (rom_addr_reg == ROM_AW'(ROM_DEPTH - 1)) ? ROM_LAST
				: ROM_FETCH;
			ROM_LAST:  rom_state_next = ROM_DONE;
			ROM_DONE:  rom_state_next = ROM_DONE;
			default:   rom_state_next = ROM_DONE;
		endcase
	end

	// ROM CRC runs only at power-on; its verdict is kept for the flag to read.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rom_state_reg <= ROM_FETCH;
			rom_addr_reg  <= '0;
			rom_valid_reg <= 1'b0;
			rom_crc_reg   <= 8'h00;
			rom_bad_reg   <= 1'b0;
		end else begin
			rom_state_reg <= rom_state_next;
			rom_valid_reg <= rom_state_reg == ROM_FETCH;
			if (rom_state_reg == ROM_FETCH) begin
				rom_addr_reg <= rom_addr_reg + ROM_AW'(1);
			end
			if (rom_valid_reg) begin
				rom_crc_reg <= dec_crc8({24'h000000, rom_crc_reg ^ i_rom_data});
			end
			rom_bad_reg <= (rom_state_reg == ROM_DONE) && (rom_crc_reg != ROM_CRC_EXPECTED);
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	property p_conv;
		enables_reg[B_CONV] && i_conv_fail |=> errors_reg[B_CONV];
	endproperty
	a_conv: assert property (p_conv) else $error("conversion failure lost");

	property p_sat;
		enables_reg[B_SAT] && i_mod_sat |=> errors_reg[B_SAT];
	endproperty
	a_sat: assert property (p_sat) else $error("saturation not flagged");

	property p_sat_off;
		!enables_reg[B_SAT] && !errors_reg[B_SAT] |=> !errors_reg[B_SAT];
	endproperty
	a_sat_off: assert property (p_sat_off) else $error("disabled check set flag");

	property p_pos_over;
		(enables_reg[B_POS_OVER] && i_pos_over)[*4] |-> ##[1:3] errors_reg[B_POS_OVER];
	endproperty
	a_pos_over: assert property (p_pos_over) else $error("overvoltage missed");

	property p_ref;
		(enables_reg[B_REF] && i_ext_ref_used && i_ref_low)[*4] |-> ##[1:3] errors_reg[B_REF];
	endproperty
	a_ref: assert property (p_ref) else $error("reference loss missed");

	property p_dldo_trip;
		enables_reg[B_DLDO_TRIP] && mon_reg[MON_DLDO] |=> errors_reg[B_DLDO_CHK];
	endproperty
	a_dldo_trip: assert property (p_dldo_trip) else $error("trip test not flagged");

	property p_locked;
		link.wr_stb && busy |=> $stable(enables_reg);
	endproperty
	a_locked: assert property (p_locked) else $error("write taken while busy");

	property p_ignored;
		link.wr_stb && busy && enables_reg[B_IGNORE] |=> errors_reg[B_IGNORE];
	endproperty
	a_ignored: assert property (p_ignored) else $error("ignored write not flagged");

	property p_sclk;
		link.cnt_bad && enables_reg[B_SCLK] |=> errors_reg[B_SCLK];
	endproperty
	a_sclk: assert property (p_sclk) else $error("clock count error missed");

	property p_read_err;
		link.rd_stb && !readable && enables_reg[B_READ] |=> errors_reg[B_READ];
	endproperty
	a_read_err: assert property (p_read_err) else $error("bad read not flagged");

	property p_write_err;
		link.wr_stb && !busy && link.addr == ADDR_ERRORS && enables_reg[B_WRITE]
			|=> errors_reg[B_WRITE] && $stable(enables_reg);
	endproperty
	a_write_err: assert property (p_write_err) else $error("bad write not flagged");

	property p_rom;
		rom_state_reg == ROM_DONE && rom_crc_reg != ROM_CRC_EXPECTED && enables_reg[B_ROM]
			|-> ##[1:2] errors_reg[B_ROM];
	endproperty
	a_rom: assert property (p_rom) else $error("ROM mismatch not flagged");

	c_write: cover property (wr_enables);
	c_clear: cover property (err_clear && snap_reg != 24'h000000);
	c_rom_done: cover property (rom_state_reg == ROM_DONE && !rom_bad_reg);
endmodule : dec_diag_checks

//--- hw/dec_link_if.sv
/*
 * Link between the serial front end and the register core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface dec_link_if;
	logic [5:0]  addr;
	logic        rd_stb;
	logic        rd_done;
	logic [23:0] rdata;
	logic        wr_stb;
	logic [23:0] wdata;
	logic        cnt_bad;
	logic        crc_bad;
	logic        crc_en;

	modport port (output addr, rd_stb, rd_done, wr_stb, wdata, cnt_bad, crc_bad,
		input rdata, crc_en);
	modport core (input addr, rd_stb, rd_done, wr_stb, wdata, cnt_bad, crc_bad,
		output rdata, crc_en);
endinterface : dec_link_if

//--- hw/dec_map_crc.sv
/*
 * Register map guard: snapshots a CRC after each write and rechecks it on a timer.
 * Assumes the capture strobe comes one cycle after the map has taken its new value.
 */
`timescale 1ns/1ps
module dec_map_crc
	import dec_pkg::*;
#(
	parameter int CHECK_CYCLES = MAP_CHECK_CYCLES
)(
	input  wire logic        i_mclk,
	input  wire logic        i_rstn,
	input  wire logic        i_enable,
	input  wire logic        i_capture,
	input  wire logic [23:0] i_map,
	output logic             o_mismatch
);
	localparam int         TW        = $clog2(CHECK_CYCLES + 1);
	localparam logic [7:0] RESET_CRC = dec_crc8({8'h00, ENABLES_RESET});

	logic [7:0]    ref_reg, now_crc;
	logic [TW-1:0] timer_reg;
	logic          tick;

	assign now_crc = dec_crc8({8'h00, i_map});
	assign tick    = timer_reg == TW'(CHECK_CYCLES - 1);

	// The timer clears to zero while disabled, so no stale recheck fires on enable.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ref_reg    <= RESET_CRC;
			timer_reg  <= '0;
			o_mismatch <= 1'b0;
		end else begin
			if (i_capture) begin
				ref_reg <= now_crc;
			end
			timer_reg  <= (!i_enable || tick) ? '0 : timer_reg + TW'(1);
			o_mismatch <= i_enable & tick & ~i_capture & (now_crc != ref_reg);
		end
	end

	property p_snapshot;
		@(posedge i_mclk) disable iff (!i_rstn)
		i_capture |=> ref_reg == dec_crc8({8'h00, $past(i_map)});
	endproperty
	a_snapshot: assert property (p_snapshot) else $error("map CRC not captured");

	property p_quiet_off;
		@(posedge i_mclk) disable iff (!i_rstn)
		!i_enable |=> !o_mismatch && timer_reg == '0;
	endproperty
	a_quiet_off: assert property (p_quiet_off) else $error("map check ran disabled");
endmodule : dec_map_crc

//--- hw/dec_pkg.sv
/*
 * Shared constants, state type and CRC function of the diagnostic check block.
 * Assumes one 10 MHz system clock for every module that imports it.
 */
package dec_pkg;
	localparam int          CLK_PERIOD_NS = 100;
	// Register map of the serial port: errors are read-only, enables read/write.
	localparam logic [5:0]  ADDR_ERRORS   = 6'h06;
	localparam logic [5:0]  ADDR_ENABLES  = 6'h07;
	localparam logic [23:0] ENABLES_RESET = 24'h000040;
	localparam logic [23:0] ERRORS_RESET  = 24'h000000;
	// Bit positions, shared by the enable and the error register.
	localparam int B_ROM        = 0;
	localparam int B_MAP        = 1;
	localparam int B_IF_CRC     = 2;
	localparam int B_WRITE      = 3;
	localparam int B_READ       = 4;
	localparam int B_SCLK       = 5;
	localparam int B_IGNORE     = 6;
	localparam int B_ALDO_CHK   = 7;
	localparam int B_ALDO_TRIP  = 8;
	localparam int B_DLDO_CHK   = 9;
	localparam int B_DLDO_TRIP  = 10;
	localparam int B_REF        = 11;
	localparam int B_NEG_UNDER  = 12;
	localparam int B_NEG_OVER   = 13;
	localparam int B_POS_UNDER  = 14;
	localparam int B_POS_OVER   = 15;
	localparam int B_SAT        = 16;
	localparam int B_CONV       = 17;
	// Positions of the analog monitor levels in the synchroniser vector.
	localparam int MON_W        = 7;
	localparam int MON_POS_OVER = 0;
	localparam int MON_POS_UNDER = 1;
	localparam int MON_NEG_OVER = 2;
	localparam int MON_NEG_UNDER = 3;
	localparam int MON_REF      = 4;
	localparam int MON_DLDO     = 5;
	localparam int MON_ALDO     = 6;
	// Serial frame layout: command byte, 24 data bits, optional CRC byte.
	localparam int         CMD_RD_BIT  = 6;
	localparam int         CMD_WEN_BIT = 7;
	localparam logic [5:0] CMD_BITS    = 6'd8;
	localparam logic [5:0] FRAME_PLAIN = 6'd32;
	localparam logic [5:0] FRAME_CRC   = 6'd40;
	localparam logic [7:0] CRC_POLY    = 8'h07;
	// Power-on window during which writes are discarded.
	localparam int POR_TIME_NS = 6400;
	localparam int POR_CYCLES  = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Period of the register map recheck.
	localparam int MAP_CHECK_TIME_US = 1000;
	localparam int MAP_CHECK_CYCLES  = MAP_CHECK_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int ROM_AW    = 4;
	localparam int ROM_DEPTH = 16;

	typedef enum {ROM_FETCH, ROM_LAST, ROM_DONE} dec_rom_state_t;

	// CRC-8, MSB first, zero seed; a leading zero byte leaves it unchanged.
	function automatic logic [7:0] dec_crc8(input logic [31:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 31; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : dec_crc8
endpackage : dec_pkg

//--- hw/dec_serial.sv
/*
 * Serial front end: frames on chip select, counts clocks, shifts data, checks CRC.
 * Assumes SCLK idles high, each SCLK phase lasts at least four system clocks.
 */
`timescale 1ns/1ps
module dec_serial
	import dec_pkg::*;
(
	input  wire logic i_mclk,
	input  wire logic i_rstn,
	input  wire logic i_cs_n,
	input  wire logic i_sclk,
	input  wire logic i_din,
	output logic      o_dout,
	output logic      o_dout_oe,
	dec_link_if.port  link
);
	logic [2:0]  s1_reg, s2_reg, s3_reg, f_reg, f_next;
	logic [5:0]  cnt_reg;
	logic [39:0] rx_reg;
	logic [31:0] tx_reg;
	logic [7:0]  cmd_reg;
	logic        rd_pend_reg;
	logic        rise, fall, cs_start, cs_end, sel, din, have_cmd, is_read, full, crc_ok;

	// Pins take three stages; a level counts once stages two and three agree.
	assign f_next   = (s2_reg & ~(s2_reg ^ s3_reg)) | (f_reg & (s2_reg ^ s3_reg));
	assign rise     = ~f_reg[1] & f_next[1];
	assign fall     = f_reg[1] & ~f_next[1];
	assign cs_start = f_reg[2] & ~f_next[2];
	assign cs_end   = ~f_reg[2] & f_next[2];
	assign sel      = ~f_reg[2];
	assign din      = f_next[0];

	// Frame decode; only the read strobe after the command byte acts before chip select closes the frame.
	assign have_cmd = cnt_reg >= CMD_BITS;
	assign is_read  = cmd_reg[CMD_RD_BIT];
	assign full     = cnt_reg == (link.crc_en ? FRAME_CRC : FRAME_PLAIN);
	assign crc_ok   = !link.crc_en || (dec_crc8({cmd_reg, rx_reg[31:8]}) == rx_reg[7:0]);
	assign link.addr    = cmd_reg[5:0];
	assign link.wdata   = link.crc_en ? rx_reg[31:8] : rx_reg[23:0];
	assign link.rd_stb  = rd_pend_reg;
	assign link.rd_done = cs_end & have_cmd & is_read & (cnt_reg >= FRAME_PLAIN);
	assign link.wr_stb  = cs_end & have_cmd & ~is_read & ~cmd_reg[CMD_WEN_BIT] & full
		& crc_ok;
	assign link.crc_bad = cs_end & have_cmd & ~is_read & link.crc_en & full & ~crc_ok;
	assign link.cnt_bad = cs_end & (cnt_reg[2:0] != 3'h0);
	assign o_dout_oe    = sel;

	// Synchroniser chain for chip select, clock and data.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1_reg <= 3'h7;
			s2_reg <= 3'h7;
			s3_reg <= 3'h7;
			f_reg  <= 3'h7;
		end else begin
			s1_reg <= {i_cs_n, i_sclk, i_din};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			f_reg  <= f_next;
		end
	end

	// Receive side: clock count saturates so a runaway frame stays flagged.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_reg     <= 6'h00;
			rx_reg      <= 40'h0;
			cmd_reg     <= 8'h00;
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= sel & rise & (cnt_reg == CMD_BITS - 6'd1) & rx_reg[CMD_RD_BIT - 1];
			if (cs_start) begin
				cnt_reg <= 6'h00;
			end else if (sel && rise) begin
				if (cnt_reg != 6'h3f) begin
					cnt_reg <= cnt_reg + 6'd1;
				end
				rx_reg <= {rx_reg[38:0], din};
				if (cnt_reg == CMD_BITS - 6'd1) begin
					cmd_reg <= {rx_reg[6:0], din};
				end
			end
		end
	end

	// Transmit side: read data, then the CRC byte when checking is on.
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_reg <= 32'h0;
			o_dout <= 1'b0;
		end else if (cs_start) begin
			tx_reg <= 32'h0;
		end else if (rd_pend_reg) begin
			tx_reg <= {link.rdata, link.crc_en ? dec_crc8({cmd_reg, link.rdata}) : 8'h00};
		end else if (sel && fall) begin
			tx_reg <= {tx_reg[30:0], 1'b0};
			o_dout <= tx_reg[31];
		end
	end

	property p_crc_append;
		@(posedge i_mclk) disable iff (!i_rstn)
		link.rd_stb && link.crc_en |=>
			tx_reg == {$past(link.rdata), dec_crc8({cmd_reg, $past(link.rdata)})};
	endproperty
	a_crc_append: assert property (p_crc_append) else $error("read CRC byte wrong");
endmodule : dec_serial

//--- tb/dec_host.sv
/* Serial host model for the diagnostic check block's register port.
   Assumes the device samples on rising SCLK and filters pins over four clocks. */
`timescale 1ns/1ps
module dec_host (
	input  wire logic i_mclk,
	input  wire logic i_dout,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_din  = 1'b0;
	end
	// Phases of six clocks leave margin over the device's pin filter.
	task automatic xfer(input logic [39:0] bits, input int n, output logic [39:0] rx);
		rx = '0;
		@(posedge i_mclk) #10 o_cs_n = 1'b0;
		repeat (8) @(posedge i_mclk);
		for (int i = 0; i < n; i++) begin
			repeat (6) @(posedge i_mclk);
			#10 o_sclk = 1'b0;
			o_din = bits[39-i];
			repeat (6) @(posedge i_mclk);
			#10 rx = {rx[38:0], i_dout};
			o_sclk = 1'b1;
		end
		repeat (6) @(posedge i_mclk);
		#10 o_cs_n = 1'b1;
		o_din = ~o_din; // A released line must not look held.
		repeat (8) @(posedge i_mclk);
	endtask : xfer
endmodule : dec_host

//--- tb/tb_top.sv
/* Self-checking bench of the diagnostic check block.
   Assumes the host model drives the serial port and the ROM image is all zero. */
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top;
	import dec_pkg::*;
	logic        i_mclk = 1'b0;
	logic        i_rstn = 1'b0;
	logic        cal    = 1'b0;
	logic [8:0]  mon    = '0;
	logic        cs_n, sclk, din, dout, doe, dtrip, atrip;
	logic [23:0] en, er;
	logic [39:0] rx;
	int          failures = 0;
	int          tests_run = 0;
	int          cycles = 0;
	localparam int bp[9] = '{B_CONV, B_SAT, B_POS_OVER, B_POS_UNDER, B_NEG_OVER,
		B_NEG_UNDER, B_REF, B_DLDO_CHK, B_ALDO_CHK};
	always #50 i_mclk = ~i_mclk;
	// Supervisors report bad while their trip test grounds them.
	// The expected ROM CRC differs from that of the all-zero image, so the ROM check must trip.
	dec_diag_checks #(.MAP_CYCLES(20), .ROM_CRC_EXPECTED(8'h5a)) dec_diag_checks_i (
		.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe(doe),
		.i_calibrating(cal), .i_conv_fail(mon[0]), .i_mod_sat(mon[1]), .i_pos_over(mon[2]),
		.i_pos_under(mon[3]), .i_neg_over(mon[4]), .i_neg_under(mon[5]),
		.i_ext_ref_used(1'b1), .i_ref_low(mon[6]), .i_dldo_bad(mon[7] | dtrip),
		.i_aldo_bad(mon[8] | atrip), .o_digital_regulator_trip_test(dtrip),
		.o_analog_regulator_trip_test(atrip), .o_rom_addr(), .i_rom_data(8'h00),
		.o_check_enables(en), .o_error_flags(er));
	dec_host host_i (.i_mclk(i_mclk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk),
		.o_din(din));
	function automatic logic [7:0] crc8(input logic [31:0] d);
		logic [7:0] c = 8'h00;
		for (int i = 31; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction : crc8
	// Mode 0 sends no CRC byte, 1 a good one, 2 a corrupted one.
	task automatic wr(input logic [5:0] a, input logic [23:0] d, input int m);
		logic [7:0] c;
		c = crc8({2'b00, a, d}) ^ 8'(m == 2);
		host_i.xfer({2'b00, a, d, c}, (m > 0) ? 40 : 32, rx);
		repeat (8) @(posedge i_mclk);
	endtask : wr
	task automatic rd(input logic [5:0] a, input int n);
		host_i.xfer({2'b01, a, 32'h0}, n, rx);
		repeat (8) @(posedge i_mclk);
	endtask : rd
	task automatic tally_and_finish;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : tally_and_finish
	// A hang counts as a mismatch; the tests need about six thousand clocks.
	always @(posedge i_mclk) begin
		cycles++;
		if (cycles == 30000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (2) @(posedge i_mclk);
		#10 i_rstn = 1'b1;
		`CHK(en, ENABLES_RESET)
		`CHK(er, ERRORS_RESET)
		`CHK(doe, 1'b0)
		repeat (100) @(posedge i_mclk);
		`CHK(er[B_ROM], 1'b0)
		#10 cal = 1'b1;
		wr(ADDR_ENABLES, 24'h03fafa, 0);
		#10 cal = 1'b0;
		`CHK(en, ENABLES_RESET)
		`CHK(er, 24'h000040)
		wr(ADDR_ENABLES, 24'h03fafa, 0);
		`CHK(en, 24'h03fafa)
		rd(ADDR_ERRORS, 32);
		`CHK(rx[23:0], 24'h000040)
		// Each monitor in turn, leaving earlier flags set.
		for (int i = 0; i < 9; i++) begin
			#10 mon[i] = 1'b1;
			repeat (8) @(posedge i_mclk);
			`CHK(er[bp[i]], 1'b1)
		end
		#10 mon = '0;
		rd(ADDR_ERRORS, 32);
		`CHK(rx[23:0], 24'h03fa80)
		rd(6'h3f, 32);
		`CHK(rx[23:0], 24'h000000)
		wr(ADDR_ERRORS, 24'h000001, 0);
		host_i.xfer(40'h0, 12, rx);
		repeat (8) @(posedge i_mclk);
		`CHK(er, 24'h000038)
		wr(ADDR_ENABLES, 24'h000780, 0);
		`CHK({dtrip, atrip}, 2'b11)
		`CHK(er, 24'h0002b8)
		wr(ADDR_ENABLES, 24'h000004, 0);
		rd(ADDR_ERRORS, 40);
		`CHK(rx[31:8], 24'h0002b8)
		`CHK(rx[7:0], crc8({2'b01, ADDR_ERRORS, 24'h0002b8}))
		#10 mon = '1;
		repeat (8) @(posedge i_mclk);
		`CHK(er, 24'h000000)
		#10 mon = '0;
		wr(ADDR_ENABLES, 24'h000006, 1);
		`CHK(en, 24'h000006)
		wr(ADDR_ENABLES, 24'h000000, 2);
		`CHK(en, 24'h000006)
		`CHK(er, 24'h000004)
		wr(ADDR_ENABLES, 24'h000007, 1);
		`CHK(en, 24'h000007)
		`CHK(er[B_ROM], 1'b1)
		tally_and_finish();
	end
endmodule : tb_top
